// ---- mct_top.sv ----
// machine-cycle sequencer: 4-clock cycles, address latch strobe,
// instruction length in machine cycles, stretched external data strobes
// assumes the core presents one request while ready is high
`timescale 1ns/100ps
`default_nettype none
module mct_top (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // instruction request from decode, transfer stretch setting and per-timer fast selects
  input  wire mct_pkg::mct_req_type           req,
  input  wire logic [2:0]                     stretch,
  input  wire logic [mct_pkg::NUM_TIMERS-1:0] timer_fast,
  // timing outputs
  output logic                                mc_tick,
  output logic                                ale,
  output logic                                ready,
  output logic                                instr_done,
  output logic [mct_pkg::NUM_TIMERS-1:0]      timer_inc,
  // port3 alternate strobes
  output logic                                port3_bit6,
  output logic                                port3_bit7
);
  import mct_pkg::*;

  logic [1:0]     phase;
  logic           mc_end;
  mct_state_type  state;
  logic [3:0]     mc_left;
  logic           xfer_wr;
  logic [2:0]     stretch_reg;
  mct_strobe_type next_strobe;

  assign mc_end = (phase == PHASE_LAST);

  // four clocks per machine cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
    end else begin
      phase <= mc_end ? 2'h0 : phase + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mc_tick <= 1'b0;
      ale     <= 1'b0;
    end else begin
      mc_tick <= mc_end;
      ale     <= (phase == PHASE_ALE);
    end
  end

  // stretch setting frozen from the take to the end of a request, so a change
  // mid-transfer cannot move the strobe edges away from the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stretch_reg <= STRETCH_RESET;
    end else if (state == MCT_IDLE && !(mc_end && req.start)) begin
      stretch_reg <= stretch;
    end
  end

  // sequencer: requests taken at a machine-cycle boundary only; no dummy cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= MCT_IDLE;
      mc_left    <= 4'h0;
      xfer_wr    <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (mc_end) begin
        case (state)
          MCT_IDLE: begin
            if (req.start && req.is_xfer) begin
              state   <= MCT_XFER;
              xfer_wr <= req.xfer_write;
              mc_left <= XFER_BASE + {1'b0, stretch_reg};
            end else if (req.start) begin
              state <= MCT_INSTR;
              // duration clamped to one..five cycles; one byte per cycle from decode
              if (req.mcycles < MC_ONE) begin
                mc_left <= {1'b0, MC_ONE};
              end else if (req.mcycles > MC_MAX) begin
                mc_left <= {1'b0, MC_MAX};
              end else begin
                mc_left <= {1'b0, req.mcycles};
              end
            end
          end
          MCT_INSTR, MCT_XFER: begin
            if (mc_left == XFER_LAST_MC) begin
              state      <= MCT_IDLE;
              mc_left    <= 4'h0;
              instr_done <= 1'b1;
            end else begin
              mc_left <= mc_left - 4'h1;
            end
          end
          default: begin
            state <= MCT_IDLE;
          end
        endcase
      end
    end
  end

  // ready tells decode that a request will be taken at this cycle end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= (state == MCT_IDLE) && (phase == 2'(PHASE_LAST - 2'h1));
    end
  end

  // from stretch one up, strobe spans the transfer's middle cycles, four clocks per stretch step
  always_comb begin
    next_strobe.wr_n = 1'b1;
    next_strobe.rd_n = 1'b1;
    if (state == MCT_XFER && mc_left != 4'h0) begin
      // stretch zero gives a two-clock strobe in the second cycle's centre
      if (stretch_reg == 3'h0) begin
        if (mc_left == XFER_LAST_MC && phase != 2'h0 && phase != PHASE_LAST) begin
          next_strobe.wr_n = !xfer_wr;
          next_strobe.rd_n = xfer_wr;
        end
      end else if (mc_left != XFER_BASE + {1'b0, stretch_reg} && mc_left != XFER_LAST_MC) begin
        next_strobe.wr_n = !xfer_wr;
        next_strobe.rd_n = xfer_wr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port3_bit6 <= 1'b1;
      port3_bit7 <= 1'b1;
    end else begin
      port3_bit6 <= next_strobe.wr_n;
      port3_bit7 <= next_strobe.rd_n;
    end
  end

  // effect of each instruction on flags stays in the datapath; only timing lives here
  mct_timer_tick u_tick (
    .clk       (clk),
    .rst       (rst),
    .mc_tick   (mc_tick),
    .fast_sel  (timer_fast),
    .timer_inc (timer_inc)
  );

  // assertion helpers: clocks since the last take, and the length in clocks
  // that the taken request must last, worked out from the rules directly
  logic       chk_take;
  logic [5:0] chk_clks;
  logic [5:0] chk_len;

  assign chk_take = mc_end && (state == MCT_IDLE) && req.start;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_clks <= 6'h00;
      chk_len  <= 6'h00;
    end else if (chk_take) begin
      chk_clks <= 6'h00;
      if (req.is_xfer) begin
        chk_len <= 6'(CLKS_PER_MC * (XFER_BASE_MC + stretch_reg));
      end else if (req.mcycles < MC_ONE) begin
        chk_len <= 6'(CLKS_PER_MC * MC_ONE);
      end else if (req.mcycles > MC_MAX) begin
        chk_len <= 6'(CLKS_PER_MC * MC_MAX);
      end else begin
        chk_len <= 6'(CLKS_PER_MC * req.mcycles);
      end
    end else if (chk_clks != 6'h3F) begin
      chk_clks <= chk_clks + 6'h01;
    end
  end

  chk_mc_period: assert property (@(posedge clk) disable iff (rst)
    mc_tick |=> !mc_tick [*3] ##1 mc_tick)
    else $error("machine cycle not four clocks");
  chk_ale_once: assert property (@(posedge clk) disable iff (rst)
    mc_tick |-> ##1 ale ##1 !ale [*3])
    else $error("address latch strobe not once per cycle");
  chk_xfer_min: assert property (@(posedge clk) disable iff (rst)
    (mc_end && state == MCT_IDLE && req.start && req.is_xfer) |=> !instr_done [*8])
    else $error("external transfer shorter than two cycles");
  chk_stretch_rst: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> stretch_reg == STRETCH_RESET)
    else $error("stretch setting not one after reset");
  chk_strobe_excl: assert property (@(posedge clk) disable iff (rst)
    !(!port3_bit6 && !port3_bit7))
    else $error("read and write strobes both active");
  chk_strobe_xfer: assert property (@(posedge clk) disable iff (rst)
    $fell(port3_bit7) |-> $past(state) == MCT_XFER && !$past(xfer_wr))
    else $error("read strobe outside read transfer");
  chk_wr_xfer: assert property (@(posedge clk) disable iff (rst)
    $fell(port3_bit6) |-> $past(state) == MCT_XFER && $past(xfer_wr))
    else $error("write strobe outside write transfer");
  chk_strobe_idle: assert property (@(posedge clk) disable iff (rst)
    $past(state) != MCT_XFER |-> port3_bit6 && port3_bit7)
    else $error("strobe active outside a transfer");
  chk_strobe_late: assert property (@(posedge clk) disable iff (rst)
    ($fell(port3_bit6) || $fell(port3_bit7)) |-> chk_clks >= 6'(CLKS_PER_MC))
    else $error("strobe began in the first machine cycle");
  chk_instr_len: assert property (@(posedge clk) disable iff (rst)
    (chk_take && !req.is_xfer && req.mcycles == 3'h3)
    |-> ##13 (instr_done && chk_clks == 6'(3 * CLKS_PER_MC)))
    else $error("three-cycle instruction length wrong");
  chk_done_span: assert property (@(posedge clk) disable iff (rst)
    instr_done |-> chk_clks == chk_len)
    else $error("request length in clocks wrong");
  chk_ready_take: assert property (@(posedge clk) disable iff (rst)
    ready |-> mc_end && state == MCT_IDLE)
    else $error("ready outside a free cycle end");
  chk_no_dummy: assert property (@(posedge clk) disable iff (rst)
    instr_done |-> state == MCT_IDLE)
    else $error("sequencer busy after completion");
endmodule
`default_nettype wire

// ---- mct_pkg.sv ----
// constants and types for the machine-cycle timing block
// assumes a single 250 MHz clock and an asynchronous active-high reset
// Operation
// - each machine cycle lasts exactly four input clocks
// - exactly one address latch strobe pulse per machine cycle
// - after reset timers advance once every twelve input clocks
// - each timer can be switched separately to advance every four clocks
// - external data transfer takes at least two machine cycles, eight clocks
// - direct-to-direct copy takes three machine cycles, twelve clocks
// - one instruction cycle per instruction byte fetched
// - instruction duration ranges from one to five machine cycles
// - instruction effects match legacy set; only cycle counts differ
// - no dummy memory cycles are inserted by the sequencer
// - port3 bit6 carries write strobe, port3 bit7 the read strobe
// - stretch 0..7 gives 2..9 cycle transfers; reset setting is one
package mct_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned CLKS_PER_MC    = 4;
  localparam int unsigned CLKS_PER_SLOW  = 12;
  localparam int unsigned SLOW_DIV_MC    = CLKS_PER_SLOW / CLKS_PER_MC;
  localparam int unsigned NUM_TIMERS     = 3;
  localparam int unsigned XFER_BASE_MC   = 2;
  localparam int unsigned MAX_INSTR_MC   = 5;
  localparam logic [1:0]  PHASE_LAST     = 2'(CLKS_PER_MC - 1);
  localparam logic [1:0]  PHASE_ALE      = 2'h0;
  localparam logic [1:0]  SLOW_LAST      = 2'(SLOW_DIV_MC - 1);
  localparam logic [2:0]  STRETCH_RESET  = 3'h1;
  localparam logic [2:0]  MC_ONE         = 3'h1;
  localparam logic [2:0]  MC_MAX         = 3'(MAX_INSTR_MC);
  localparam logic [3:0]  XFER_BASE      = 4'(XFER_BASE_MC);
  localparam logic [3:0]  XFER_LAST_MC   = 4'h1;

  typedef enum logic [1:0] {
    MCT_IDLE = 2'b00,
    MCT_INSTR = 2'b01,
    MCT_XFER = 2'b10
  } mct_state_type;

  // one request from the core's decode stage
  typedef struct packed {
    logic       start;
    logic       is_xfer;
    logic       xfer_write;
    logic [2:0] mcycles;
  } mct_req_type;

  // port3 alternate strobes, active low on the pins
  typedef struct packed {
    logic wr_n;
    logic rd_n;
  } mct_strobe_type;
endpackage

// ---- mct_timer_tick.sv ----
// per-timer increment enable from a shared divide-by-three of machine cycles
// assumes mc_tick pulses once per machine cycle
`timescale 1ns/100ps
`default_nettype none
module mct_timer_tick (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rst,
  // machine-cycle pulse and per-timer fast select
  input  wire logic                               mc_tick,
  input  wire logic [mct_pkg::NUM_TIMERS-1:0]     fast_sel,
  // per-timer increment enables
  output logic      [mct_pkg::NUM_TIMERS-1:0]     timer_inc
);
  import mct_pkg::*;
  logic [1:0] slow_cnt;
  logic       slow_tick;

  // one divider for all timers keeps their slow ticks in step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_cnt <= 2'h0;
    end else if (mc_tick) begin
      slow_cnt <= (slow_cnt == SLOW_LAST) ? 2'h0 : slow_cnt + 2'h1;
    end
  end
  assign slow_tick = mc_tick && (slow_cnt == SLOW_LAST);

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          timer_inc[g] <= 1'b0;
        end else begin
          timer_inc[g] <= fast_sel[g] ? mc_tick : slow_tick;
        end
      end
    end
  endgenerate

  // assertion helpers for timer 0: clocks since its last increment, and whether
  // every select since then asked for the slow rate (a switch may shorten a gap)
  logic [4:0] chk_gap;
  logic       chk_fast_q;
  logic       chk_slow_run;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_gap      <= 5'h00;
      chk_fast_q   <= 1'b0;
      chk_slow_run <= 1'b0;
    end else begin
      chk_fast_q <= fast_sel[0];
      if (timer_inc[0]) begin
        chk_gap      <= 5'h01;
        chk_slow_run <= !fast_sel[0] && !chk_fast_q;
      end else begin
        chk_gap      <= (chk_gap == 5'h1F) ? chk_gap : chk_gap + 5'h01;
        chk_slow_run <= chk_slow_run && !fast_sel[0];
      end
    end
  end

  chk_slow_gap: assert property (@(posedge clk) disable iff (rst)
    (timer_inc[0] && chk_slow_run && !chk_fast_q) |-> chk_gap == 5'(CLKS_PER_SLOW))
    else $error("slow timer ticks not twelve clocks apart");
endmodule
`default_nettype wire

// ---- mct_xmem_model.sv ----
// external data memory model: measures each read and write strobe
// assumes active-low strobes, sampled on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module mct_xmem_model (
  // clock
  input  wire logic       clk,
  // strobes from the block
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  // width in clocks of the last finished strobe
  output logic      [5:0] rd_width,
  output logic      [5:0] wr_width
);
  logic [5:0] rd_cnt;
  logic [5:0] wr_cnt;

  initial begin
    rd_cnt   = 6'h00;
    wr_cnt   = 6'h00;
    rd_width = 6'h00;
    wr_width = 6'h00;
  end

  // read strobe on port3_bit7, write strobe on port3_bit6
  always @(posedge clk) begin
    if (rd_n === 1'b0) begin
      rd_cnt <= rd_cnt + 6'h01;
    end else if (rd_cnt != 6'h00) begin
      rd_width <= rd_cnt;
      rd_cnt   <= 6'h00;
    end
    if (wr_n === 1'b0) begin
      wr_cnt <= wr_cnt + 6'h01;
    end else if (wr_cnt != 6'h00) begin
      wr_width <= wr_cnt;
      wr_cnt   <= 6'h00;
    end
  end
endmodule
`default_nettype wire

// ---- mct_top_tb.sv ----
// self-checking bench for the machine-cycle timing block
// assumes the memory model watches the strobes; inputs move 1 ns after clk rises
`timescale 1ns/100ps
`default_nettype none
module mct_top_tb;
  import mct_pkg::*;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  mct_req_type           req = '0;
  logic [2:0]            stretch = 3'h1;
  logic [NUM_TIMERS-1:0] timer_fast = '0;
  logic                  mc_tick, ale, ready, instr_done;
  logic [NUM_TIMERS-1:0] timer_inc;
  logic                  port3_bit6, port3_bit7;
  logic [5:0]            rd_width, wr_width;
  int                    n_mismatch = 0;
  int                    cmp_count = 0;

  always #2 clk = ~clk;

  mct_top i_dut (.clk(clk), .rst(rst), .req(req), .stretch(stretch),
    .timer_fast(timer_fast), .mc_tick(mc_tick), .ale(ale), .ready(ready),
    .instr_done(instr_done), .timer_inc(timer_inc),
    .port3_bit6(port3_bit6), .port3_bit7(port3_bit7));

  mct_xmem_model i_mem (.clk(clk), .wr_n(port3_bit6), .rd_n(port3_bit7),
    .rd_width(rd_width), .wr_width(wr_width));

  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // counts strobes over 48 clocks, a whole number of every period
  task automatic s_ticks(input logic [2:0] fast);
    logic [7:0] n_ale;
    logic [7:0] n_mc;
    logic [7:0] n_t [0:2];
    n_ale = 8'h00;
    n_mc = 8'h00;
    n_t = '{8'h00, 8'h00, 8'h00};
    timer_fast = fast;
    repeat (8) @(posedge clk);
    #1;
    repeat (48) begin
      @(posedge clk);
      #1;
      n_ale += 8'(ale === 1'b1);
      n_mc += 8'(mc_tick === 1'b1);
      for (int i = 0; i < 3; i++) n_t[i] += 8'(timer_inc[i] === 1'b1);
    end
    cmp(8'h0C, n_ale);
    cmp(8'h0C, n_mc);
    for (int i = 0; i < 3; i++) cmp(fast[i] ? 8'h0C : 8'h04, n_t[i]);
  endtask

  // one request held until taken; returns clocks from take to done
  task automatic run_req(input logic x, input logic w, input logic [2:0] mc,
                         output logic [7:0] clks);
    int n;
    req = '{start: 1'b1, is_xfer: x, xfer_write: w, mcycles: mc};
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    req = '0;
    n = (n >= 20) ? 99 : 0;
    while (instr_done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      n_mismatch++;
      summarize();
    end
    clks = 8'(n);
  endtask

  // every mcycles code, back to back; out-of-range codes clamp to 1..5
  task automatic s_instr;
    logic [7:0] c;
    for (int m = 0; m < 8; m++) begin
      run_req(1'b0, 1'b0, 3'(m), c);
      cmp(8'(4 * (m == 0 ? 1 : (m > 5 ? 5 : m))), c);
    end
  endtask

  // every stretch value, reads and writes alternating
  task automatic s_xfer;
    logic [7:0] c;
    logic       w;
    for (int s = 0; s < 8; s++) begin
      w = 1'(s);
      stretch = 3'(s);
      repeat (2) @(posedge clk);
      #1;
      run_req(1'b1, w, 3'h1, c);
      cmp(8'(4 * (2 + s)), c);
      repeat (3) @(posedge clk);
      #1;
      cmp(8'(s == 0 ? 2 : 4 * s), 8'(w ? wr_width : rd_width));
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    s_ticks(3'b000);
    s_ticks(3'b101);
    s_instr();
    s_xfer();
    summarize();
  end
endmodule
`default_nettype wire
